/* File: pkg/ssa_map.vh */
// Constants for the simultaneous-sampling converter sequencer.
`ifndef SSA_MAP_VH
`define SSA_MAP_VH
// Mode code field positions.
`define SSA_MODE_PD_BIT 3
`define SSA_MODE_BANK_BIT 2
`define SSA_MODE_CNT_HI 1
`define SSA_MODE_CNT_LO 0
`define SSA_MODE_RESET 4'h0
// Times in nanoseconds.
`define SSA_CONV_TIME_NS 3000
`define SSA_STARTUP_TIME_NS 5000
`define SSA_CLK_PERIOD_NS 4
// Sequencer states.
`define SSA_ST_IDLE 3'h0
`define SSA_ST_CONV 3'h1
`define SSA_ST_DONE 3'h2
`define SSA_ST_PDOWN 3'h3
`define SSA_ST_WAKE 3'h4
`endif

/* File: logic/ssa_result_mem.v */
// Four-word result store with registered read data.
`timescale 1ns/1ns
module ssa_result_mem #(
    parameter DATA_W = 14,
    parameter ADDR_W = 2
) (
    input wire clk_in,
    input wire wr_en_in,
    input wire [ADDR_W-1:0] wr_addr_in,
    input wire [DATA_W-1:0] wr_data_in,
    input wire [ADDR_W-1:0] rd_addr_in,
    output reg [DATA_W-1:0] rd_data_out
);
    reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always @(posedge clk_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_addr_in];
    end
endmodule

/* File: logic/ssa_sequencer.v */
// Sequencer and parallel bus logic of a four-track/hold converter.
//
// Behaviour
// - Trigger rising edge starts sampling and conversion.
// - Done output falls when sequence completes.
// - Each channel takes 3 us of conversion.
// - Rates follow from per-channel conversion time.
// - Results are 14 bits, bit 13 MSB.
// - Low four bus lines carry mode code.
// - Wait 5 us after leaving power-down.
// - Bit3 power-down, bit2 bank, bits1..0 count.
// - Mode persists until rewritten.
// - Trigger ignored while sequence in progress.
// - Reads return channel order, wrap to channel 0.
`timescale 1ns/1ns
`include "ssa_map.vh"
module ssa_sequencer #(
    parameter DATA_W = 14,
    parameter CONV_CYC = (`SSA_CONV_TIME_NS + `SSA_CLK_PERIOD_NS - 1) /
        `SSA_CLK_PERIOD_NS,
    parameter WAKE_CYC = (`SSA_STARTUP_TIME_NS + `SSA_CLK_PERIOD_NS - 1) /
        `SSA_CLK_PERIOD_NS
) (
    input wire clk_in,
    input wire reset_n_in,
    input wire sample_trigger_in,
    input wire chip_select_n_in,
    input wire write_n_in,
    input wire read_n_in,
    input wire [DATA_W-1:0] result_bus_in,
    output reg [DATA_W-1:0] result_bus_out,
    output wire result_bus_oe_n_out,
    output wire done_n_out,
    output wire [1:0] track_channel_out,
    output wire bank_b_sel_out,
    output wire power_down_out,
    output reg sample_hold_out,
    input wire [DATA_W-1:0] adc_data_in
);
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    reg [3:0] mode_ff;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [12:0] cnt_ff;
    reg [12:0] nxt_cnt;
    reg [1:0] conv_ch_ff;
    reg [1:0] rd_ptr_ff;
    reg [1:0] run_last_ff;
    reg done_n_ff;
    reg trig_d_ff;
    reg wr_d_ff;
    reg rd_d_ff;
    reg cs_d_ff;
    wire [DATA_W-1:0] mem_rd_data;
    wire mem_wr;
    wire trig_rise;
    wire wr_end;
    wire rd_fall;
    wire rd_rise;
    wire [1:0] last_ch;

    function is_power_down;
        input [3:0] code;
        begin
            is_power_down = code[`SSA_MODE_PD_BIT];
        end
    endfunction

    // ------------------------------------------------------------
    // Strobe edges
    // ------------------------------------------------------------
    // The sequencer keeps running while the host strobes the bus,
    // so all edges are detected on plain samples.
    assign trig_rise = sample_trigger_in & ~trig_d_ff;
    // Write ends on the strobe or the select rising, select low before.
    assign wr_end = ~cs_d_ff & ~wr_d_ff &
        (write_n_in | chip_select_n_in);
    assign rd_fall = ~chip_select_n_in & ~read_n_in & rd_d_ff;
    assign rd_rise = ~chip_select_n_in & read_n_in & ~rd_d_ff;
    assign last_ch = run_last_ff;

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            trig_d_ff <= 1'b0;
            wr_d_ff <= 1'b1;
            rd_d_ff <= 1'b1;
            cs_d_ff <= 1'b1;
        end else begin
            trig_d_ff <= sample_trigger_in;
            wr_d_ff <= write_n_in;
            rd_d_ff <= read_n_in;
            cs_d_ff <= chip_select_n_in;
        end
    end

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    // A write during a running sequence switches the bank at once; count and power-down take effect for the next one.
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            mode_ff <= `SSA_MODE_RESET;
        end else if (wr_end) begin
            mode_ff <= result_bus_in[`SSA_MODE_PD_BIT:`SSA_MODE_CNT_LO];
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            `SSA_ST_IDLE, `SSA_ST_DONE: begin
                if (is_power_down(mode_ff)) begin
                    nxt_state = `SSA_ST_PDOWN;
                end else if (trig_rise) begin
                    nxt_state = `SSA_ST_CONV;
                    nxt_cnt = 13'h0000;
                end
            end
            `SSA_ST_CONV: begin
                // Triggers are not looked at here.
                if (cnt_ff == CONV_CYC[12:0] - 13'h0001) begin
                    nxt_cnt = 13'h0000;
                    if (conv_ch_ff == last_ch) begin
                        nxt_state = `SSA_ST_DONE;
                    end
                end else begin
                    nxt_cnt = cnt_ff + 13'h0001;
                end
            end
            `SSA_ST_PDOWN: begin
                if (!is_power_down(mode_ff)) begin
                    nxt_state = `SSA_ST_WAKE;
                    nxt_cnt = 13'h0000;
                end
            end
            `SSA_ST_WAKE: begin
                // Triggers during wake-up are dropped.
                if (cnt_ff == WAKE_CYC[12:0] - 13'h0001) begin
                    nxt_state = `SSA_ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff + 13'h0001;
                end
            end
            default: begin
                nxt_state = `SSA_ST_IDLE;
            end
        endcase
    end

    assign mem_wr = (state_ff == `SSA_ST_CONV) &&
        (cnt_ff == CONV_CYC[12:0] - 13'h0001);

    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_ff <= `SSA_ST_IDLE;
            cnt_ff <= 13'h0000;
            conv_ch_ff <= 2'h0;
            run_last_ff <= 2'h0;
            sample_hold_out <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            // The count is frozen at the trigger, so a mode write during a
            // sequence cannot cut it short or lose the read wrap point.
            if (state_ff != `SSA_ST_CONV && nxt_state == `SSA_ST_CONV) begin
                run_last_ff <= mode_ff[`SSA_MODE_CNT_HI:`SSA_MODE_CNT_LO];
            end
            sample_hold_out <= (nxt_state == `SSA_ST_CONV);
            if (state_ff != `SSA_ST_CONV) begin
                conv_ch_ff <= 2'h0;
            end else if (mem_wr) begin
                conv_ch_ff <= conv_ch_ff + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Done flag and read pointer
    // ------------------------------------------------------------
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            done_n_ff <= 1'b1;
            rd_ptr_ff <= 2'h0;
        end else begin
            if (mem_wr && conv_ch_ff == last_ch) begin
                done_n_ff <= 1'b0;
                rd_ptr_ff <= 2'h0;
            end else begin
                if (rd_fall || trig_rise) begin
                    done_n_ff <= 1'b1;
                end
                if (rd_rise) begin
                    if (rd_ptr_ff >= last_ch) begin
                        rd_ptr_ff <= 2'h0;
                    end else begin
                        rd_ptr_ff <= rd_ptr_ff + 2'h1;
                    end
                end
            end
        end
    end

    ssa_result_mem #(
        .DATA_W(DATA_W),
        .ADDR_W(2)
    ) u_mem (
        .clk_in(clk_in),
        .wr_en_in(mem_wr),
        .wr_addr_in(conv_ch_ff),
        .wr_data_in(adc_data_in),
        .rd_addr_in(rd_ptr_ff),
        .rd_data_out(mem_rd_data)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            result_bus_out <= {DATA_W{1'b0}};
        end else begin
            result_bus_out <= mem_rd_data;
        end
    end

    // Bus driven only during a selected read.
    assign result_bus_oe_n_out = chip_select_n_in | read_n_in;
    assign done_n_out = done_n_ff;
    assign track_channel_out = conv_ch_ff;
    assign bank_b_sel_out = mode_ff[`SSA_MODE_BANK_BIT];
    assign power_down_out = (state_ff == `SSA_ST_PDOWN);
endmodule

/* File: verification/ssa_sequencer_sva.sv */
// Port checker for the converter sequencer.
`timescale 1ns/1ns
module ssa_sequencer_sva #(
    parameter CONV_CYC = 8
) (
    input wire clk_in,
    input wire reset_n_in,
    input wire sample_trigger_in,
    input wire chip_select_n_in,
    input wire write_n_in,
    input wire read_n_in,
    input wire result_bus_oe_n_out,
    input wire done_n_out,
    input wire [1:0] track_channel_out,
    input wire bank_b_sel_out,
    input wire power_down_out,
    input wire sample_hold_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    reg [7:0] hold_cnt_ff;
    always @(posedge clk_in) begin
        hold_cnt_ff <= (reset_n_in && sample_hold_out) ? hold_cnt_ff + 8'h01
            : 8'h00;
    end
    sequence s_seq_end;
        $fell(sample_hold_out);
    endsequence
    property p_oe;
        result_bus_oe_n_out == (chip_select_n_in || read_n_in);
    endproperty
    a_oe: assert property (p_oe) else $error("bus enable wrong");
    property p_start;
        $rose(sample_hold_out) |-> $past(sample_trigger_in, 1) &&
            !$past(sample_trigger_in, 2) && track_channel_out == 2'h0;
    endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_len;
        s_seq_end |-> hold_cnt_ff == CONV_CYC * ($past(track_channel_out) + 1);
    endproperty
    a_len: assert property (p_len) else $error("bad length");
    property p_done;
        s_seq_end |-> $fell(done_n_out);
    endproperty
    a_done: assert property (p_done) else $error("done not low");
    property p_step;
        sample_hold_out && $past(sample_hold_out) &&
            $changed(track_channel_out) |->
            track_channel_out == $past(track_channel_out) + 2'h1;
    endproperty
    a_step: assert property (p_step) else $error("channel skip");
    property p_clear;
        !done_n_out && !chip_select_n_in && $fell(read_n_in) |->
            ##[1:2] done_n_out;
    endproperty
    a_clear: assert property (p_clear) else $error("done kept");
    property p_wake;
        $fell(power_down_out) |-> !sample_hold_out [*8];
    endproperty
    a_wake: assert property (p_wake) else $error("early start");
    property p_pd;
        power_down_out |-> !sample_hold_out;
    endproperty
    a_pd: assert property (p_pd) else $error("converting in sleep");
    property p_mode;
        $changed(bank_b_sel_out) |->
            $past(!chip_select_n_in && !write_n_in, 2) ||
            $past(!chip_select_n_in && !write_n_in, 3);
    endproperty
    a_mode: assert property (p_mode) else $error("stray mode");
endmodule

/* File: verification/ssa_conv_model.sv */
// Behavioural converter core returning a tagged word.
`timescale 1ns/1ns
module ssa_conv_model (
    input wire [1:0] track_in,
    input wire bank_in,
    input wire [10:0] salt_in,
    output wire [13:0] data_out
);
    // Channel and bank in the top bits make a misordered read visible.
    assign data_out = {track_in, bank_in, salt_in};
endmodule

/* File: verification/simultaneous_sample_adc_sequencer_test.sv */
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ns
module simultaneous_sample_adc_sequencer_test;
    reg clk_in = 1'b0;
    reg reset_n_in = 1'b0;
    reg trig = 1'b0;
    reg cs_n = 1'b1;
    reg wr_n = 1'b1;
    reg rd_n = 1'b1;
    reg [13:0] bus = 14'h0000;
    reg [10:0] salt = 11'h000;
    wire [13:0] rdata;
    wire [13:0] adc;
    wire [1:0] trk;
    wire oe_n, done_n, bank, pd, hold;
    integer err_count = 0, checks_done = 0, rcnt = 0, i, m, t;
    logic [13:0] expq[$];
    always #2 clk_in = ~clk_in;
    ssa_sequencer #(.CONV_CYC(8), .WAKE_CYC(10)) u_dut(.clk_in(clk_in),
        .reset_n_in(reset_n_in), .sample_trigger_in(trig),
        .chip_select_n_in(cs_n), .write_n_in(wr_n), .read_n_in(rd_n),
        .result_bus_in(bus), .result_bus_out(rdata),
        .result_bus_oe_n_out(oe_n), .done_n_out(done_n),
        .track_channel_out(trk), .bank_b_sel_out(bank),
        .power_down_out(pd), .sample_hold_out(hold), .adc_data_in(adc));
    ssa_conv_model u_conv(.track_in(trk), .bank_in(bank), .salt_in(salt),
        .data_out(adc));
    task check(input string name, input [13:0] exp, input [13:0] seen);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
        end
    endtask
    task print_verdict;
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task tick(input integer k);
        repeat (k) @(posedge clk_in);
    endtask
    task write_mode(input [3:0] code, input sel_n);
        @(posedge clk_in);
        cs_n <= sel_n;
        wr_n <= 1'b0;
        bus <= {10'h000, code};
        tick(2);
        wr_n <= 1'b1;
        cs_n <= 1'b1;
        tick(1);
    endtask
    // Retriggers mid-sequence must neither restart nor stretch it.
    task convert(input integer nch, input b);
        @(posedge clk_in);
        trig <= 1'b1;
        salt <= 11'($urandom);
        t = 0;
        while (done_n !== 1'b0 && t < 300) begin
            @(posedge clk_in);
            t = t + 1;
            if (t == 2 || t == 6) trig <= 1'b0;
            if (t == 4) trig <= 1'b1;
        end
        if (t >= 300) begin
            err_count = err_count + 1;
            print_verdict;
        end
        check("done time", nch * 8 + 2, t[13:0]);
        for (i = 0; i <= nch; i = i + 1) begin
            expq.push_back({2'(i % nch), b, salt});
            @(posedge clk_in);
            cs_n <= 1'b0;
            rd_n <= 1'b0;
            tick(4);
            // Select stays low over the read rising edge that moves the pointer.
            rd_n <= 1'b1;
            tick(1);
            cs_n <= 1'b1;
        end
    endtask
    always @(posedge clk_in) begin
        #1;
        rcnt = (!cs_n && !rd_n) ? rcnt + 1 : 0;
        if (rcnt == 4 && expq.size() > 0) begin
            check("read word", expq.pop_front(), rdata);
        end
    end
    initial begin
        void'($urandom(32'hba76));
        tick(20);
        reset_n_in <= 1'b1;
        convert(1, 1'b0);
        for (m = 0; m < 8; m = m + 1) begin
            write_mode(m[3:0], 1'b0);
            convert(m % 4 + 1, m[2]);
        end
        write_mode(4'h0, 1'b1);
        convert(4, 1'b1);
        write_mode(4'h8, 1'b0);
        trig <= 1'b1;
        tick(3);
        trig <= 1'b0;
        tick(30);
        check("sleep", 14'h0001, {13'h0000, pd});
        check("sleep done", 14'h0001, {13'h0000, done_n});
        write_mode(4'h5, 1'b0);
        tick(14);
        convert(2, 1'b1);
        print_verdict;
    end
endmodule
bind ssa_sequencer ssa_sequencer_sva #(.CONV_CYC(CONV_CYC)) u_sva(
    .clk_in(clk_in), .reset_n_in(reset_n_in),
    .sample_trigger_in(sample_trigger_in),
    .chip_select_n_in(chip_select_n_in), .write_n_in(write_n_in),
    .read_n_in(read_n_in), .result_bus_oe_n_out(result_bus_oe_n_out),
    .done_n_out(done_n_out), .track_channel_out(track_channel_out),
    .bank_b_sel_out(bank_b_sel_out), .power_down_out(power_down_out),
    .sample_hold_out(sample_hold_out));
